// *** rtl/cache_sram_pkg.sv ***
// package for the cache data sram with bypass
// assumes a single clock domain; shared by the array and its bench
package cache_sram_pkg;

  // ********************************************************************
  // sizes and reset values
  // ********************************************************************
  localparam int unsigned WORDS_DEFAULT      = 512;
  localparam int unsigned DATA_WIDTH_DEFAULT = 64;
  localparam int unsigned ENABLES_DEFAULT    = 8;

  // output register after reset; contents of the core are never reset
  localparam logic [63:0] DOUT_RESET         = 64'h0000_0000_0000_0000;

  // cycle kinds taken from the sampled enables
  typedef enum logic [1:0] {
    CYCLE_IDLE,
    CYCLE_READ,
    CYCLE_WRITE,
    CYCLE_BYPASS
  } cycle_type;

  // controls captured at the rising edge
  typedef struct packed {
    logic       word_line;
    logic       bypass_write;
    logic       power_down;
  } ctrl_type;

endpackage

// *** rtl/cache_sram_bypass_array.sv ***
// cache data sram: registered address, data and enables, with bypass path
// assumes the cache control logic drives all inputs synchronous to CORE_CLK
`timescale 1ns/10ps

// Notes on behaviour
// - all inputs but the asynchronous RESET_N are captured on the rising edge of the single clock.
// - address width equals log2 of the number of words.
// - sampled word line enable gives a read or write the next cycle.
// - core written only when word line and bypass/write were both sampled set.
// - bypass/write without word line forwards the registered data, core untouched.
// - output is the stored word on read, registered input data on write.
// - second cycle after bypass/write sampled, output shows the registered input data.
// - a vector of enables starts a write when any bit is set.
// - only one clock enters; no other clock is made or used.
// - clock hold keeps the input data register at its old value.
// - clock hold exists on this data array only.
// - power down for a cycle leaves stored contents intact.
module cache_sram_bypass_array #(
  parameter int unsigned WORDS      = cache_sram_pkg::WORDS_DEFAULT,
  parameter int unsigned DATA_WIDTH = cache_sram_pkg::DATA_WIDTH_DEFAULT,
  parameter int unsigned ENABLES    = cache_sram_pkg::ENABLES_DEFAULT,
  parameter int unsigned ADDR_WIDTH = $clog2(WORDS)
) (
  // clock and reset
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESET_N,
  // access request
  input  wire logic [ADDR_WIDTH-1:0]   ADDRESS_IN,
  input  wire logic                    WORD_LINE_ENABLE,
  input  wire logic [ENABLES-1:0]      BYPASS_WRITE_ENABLE,
  input  wire logic [DATA_WIDTH-1:0]   WRITE_DATA_IN,
  input  wire logic                    CLOCK_HOLD,
  input  wire logic                    POWER_DOWN,
  // answer
  output logic      [DATA_WIDTH-1:0]   DATA_OUT
);

  // ********************************************************************
  // input registers
  // ********************************************************************
  logic [ADDR_WIDTH-1:0]       address;
  logic [DATA_WIDTH-1:0]       data_in;
  cache_sram_pkg::ctrl_type    ctrl;
  logic [ADDR_WIDTH-1:0]       next_address;
  logic [DATA_WIDTH-1:0]       next_data_in;
  cache_sram_pkg::ctrl_type    next_ctrl;

  // capture inputs; clock hold freezes only the data register
  always_comb
  begin
    next_address           = ADDRESS_IN;
    next_ctrl.word_line    = WORD_LINE_ENABLE;
    next_ctrl.bypass_write = |BYPASS_WRITE_ENABLE;
    next_ctrl.power_down   = POWER_DOWN;
    next_data_in           = CLOCK_HOLD ? data_in : WRITE_DATA_IN;
  end

  // control is reset so the first cycle after release is idle
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ctrl <= '0;
    end
    else
    begin
      ctrl <= next_ctrl;
    end
  end

  // address and data carry no reset, like the array itself
  always_ff @(posedge CORE_CLK)
  begin
    address <= next_address;
    data_in <= next_data_in;
  end

  // ********************************************************************
  // cycle decode
  // ********************************************************************
  cache_sram_pkg::cycle_type cycle;

  // power down suppresses the access for that cycle only
  always_comb
  begin
    if (ctrl.power_down)
    begin
      cycle = cache_sram_pkg::CYCLE_IDLE;
    end
    else if (ctrl.word_line && ctrl.bypass_write)
    begin
      cycle = cache_sram_pkg::CYCLE_WRITE;
    end
    else if (ctrl.word_line)
    begin
      cycle = cache_sram_pkg::CYCLE_READ;
    end
    else if (ctrl.bypass_write)
    begin
      cycle = cache_sram_pkg::CYCLE_BYPASS;
    end
    else
    begin
      cycle = cache_sram_pkg::CYCLE_IDLE;
    end
  end

  // ********************************************************************
  // core and output
  // ********************************************************************
  logic [DATA_WIDTH-1:0] core [WORDS];
  logic [DATA_WIDTH-1:0] next_data_out;
  logic                  write_now;

  // output chooses stored word or registered data; holds when idle
  always_comb
  begin
    write_now = 1'b0;
    next_data_out = DATA_OUT;
    case (cycle)
      cache_sram_pkg::CYCLE_READ:
      begin
        next_data_out = core[address];
      end
      cache_sram_pkg::CYCLE_WRITE:
      begin
        write_now     = 1'b1;
        next_data_out = data_in;
      end
      cache_sram_pkg::CYCLE_BYPASS:
      begin
        next_data_out = data_in;
      end
      default:
      begin
        next_data_out = DATA_OUT;
      end
    endcase
  end

  // single clock drives the core; no derived clocks are needed
  always_ff @(posedge CORE_CLK)
  begin
    if (write_now)
    begin
      core[address] <= data_in;
    end
  end

  // output register
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      DATA_OUT <= cache_sram_pkg::DOUT_RESET[DATA_WIDTH-1:0];
    end
    else
    begin
      DATA_OUT <= next_data_out;
    end
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  property p_write_forwards;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (WORD_LINE_ENABLE && |BYPASS_WRITE_ENABLE && !POWER_DOWN && !CLOCK_HOLD)
      |=> ##1 (DATA_OUT == $past(WRITE_DATA_IN, 2));
  endproperty
  a_write_forwards: assert property (p_write_forwards)
    else $error("write data not forwarded");

  property p_bypass_forwards;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (!WORD_LINE_ENABLE && |BYPASS_WRITE_ENABLE && !POWER_DOWN && !CLOCK_HOLD)
      |=> ##1 (DATA_OUT == $past(WRITE_DATA_IN, 2));
  endproperty
  a_bypass_forwards: assert property (p_bypass_forwards)
    else $error("bypass data not forwarded");

  property p_hold_keeps;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    CLOCK_HOLD |=> (data_in == $past(data_in));
  endproperty
  a_hold_keeps: assert property (p_hold_keeps)
    else $error("data register moved under hold");

  property p_write_needs_both;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    write_now |-> ($past(WORD_LINE_ENABLE) && $past(|BYPASS_WRITE_ENABLE)
                   && !$past(POWER_DOWN));
  endproperty
  a_write_needs_both: assert property (p_write_needs_both)
    else $error("write without both enables");

  property p_no_access_idle;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (!WORD_LINE_ENABLE && !(|BYPASS_WRITE_ENABLE)) |=> (!write_now ##1 $stable(DATA_OUT));
  endproperty
  a_no_access_idle: assert property (p_no_access_idle)
    else $error("access with no enable");

  property p_powerdown_idle;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    POWER_DOWN |=> (!write_now ##1 $stable(DATA_OUT));
  endproperty
  a_powerdown_idle: assert property (p_powerdown_idle)
    else $error("access during power down");

  property p_any_enable;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (WORD_LINE_ENABLE && BYPASS_WRITE_ENABLE != '0 && !POWER_DOWN) |=> write_now;
  endproperty
  a_any_enable: assert property (p_any_enable)
    else $error("single enable bit did not write");

  property p_read_next;
    @(posedge CORE_CLK) disable iff (!RESET_N)
    (WORD_LINE_ENABLE && !(|BYPASS_WRITE_ENABLE) && !POWER_DOWN)
      |=> (cycle == cache_sram_pkg::CYCLE_READ) ##1 (DATA_OUT == $past(core[address]));
  endproperty
  a_read_next: assert property (p_read_next)
    else $error("read not performed");

  c_write:  cover property (@(posedge CORE_CLK) cycle == cache_sram_pkg::CYCLE_WRITE);
  c_read:   cover property (@(posedge CORE_CLK) cycle == cache_sram_pkg::CYCLE_READ);
  c_bypass: cover property (@(posedge CORE_CLK) cycle == cache_sram_pkg::CYCLE_BYPASS);
  c_hold:   cover property (@(posedge CORE_CLK) CLOCK_HOLD ##1 write_now);

endmodule

// *** tb/cache_ctrl_model.sv ***
// model of the cache control logic that drives the data array request pins
// assumes the bench calls issue once per clock cycle, in order
`timescale 1ns/10ps
module cache_ctrl_model (
  // clock
  input  wire logic        clk,
  // request pins toward the array
  output logic [8:0]       address,
  output logic             word_line,
  output logic [7:0]       bypass_write,
  output logic [63:0]      write_data,
  output logic             clock_hold,
  output logic             power_down
);
  // quiet pins before the first request
  initial
  begin
    {address, word_line, bypass_write, write_data, clock_hold, power_down} = '0;
  end

  // one request per cycle, launched just after the rising edge
  task automatic issue(input cache_sram_pkg::cycle_type kind, input logic [8:0] a,
                       input logic [63:0] d, input logic [7:0] be, input logic h,
                       input logic p);
    logic wr;
    logic by;
    wr = (kind == cache_sram_pkg::CYCLE_WRITE);
    by = (kind == cache_sram_pkg::CYCLE_BYPASS);
    @(posedge clk);
    #1;
    address      = a;
    word_line    = wr | (kind == cache_sram_pkg::CYCLE_READ);
    bypass_write = (wr | by) ? ((be == 8'h00) ? 8'h01 : be) : 8'h00;
    // data lines unused this cycle flip, so a stale value is never trusted
    write_data   = (wr | by) ? d : ~write_data;
    clock_hold   = h;
    power_down   = p;
  endtask
endmodule

// *** tb/tb.sv ***
// self-checking bench for the cache data array with bypass
// assumes default sizes: 512 words, 64 data bits, 8 enables
`timescale 1ns/10ps
module tb;
  logic            core_clk;
  logic            reset_n;
  logic [8:0]      address;
  logic            word_line;
  logic [7:0]      bypass_write;
  logic [63:0]     write_data;
  logic            clock_hold;
  logic            power_down;
  logic [63:0]     data_out;
  logic [63:0]     mem [logic [8:0]];
  logic [63:0]     pend [$];
  logic [63:0]     data_reg;
  logic [63:0]     out_model;
  logic [31:0]     r;
  int              miscompares;
  int              compares;
  int              cycles;
  int              seed;

  // ****************************************************
  // design and control model
  // ****************************************************
  cache_sram_bypass_array cache_sram_bypass_array_i (.CORE_CLK(core_clk), .RESET_N(reset_n),
    .ADDRESS_IN(address), .WORD_LINE_ENABLE(word_line), .BYPASS_WRITE_ENABLE(bypass_write),
    .WRITE_DATA_IN(write_data), .CLOCK_HOLD(clock_hold), .POWER_DOWN(power_down),
    .DATA_OUT(data_out));
  cache_ctrl_model cache_ctrl_model_i (.clk(core_clk), .address(address),
    .word_line(word_line), .bypass_write(bypass_write), .write_data(write_data),
    .clock_hold(clock_hold), .power_down(power_down));

  // 200 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // a hang counts as a mismatch
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // ****************************************************
  // expectation, compare and verdict
  // ****************************************************
  // one edge samples the pins, the next one shows the result; the model's own pins are
  // read, since the port connection to the bench may not have settled yet
  function automatic logic [63:0] predict();
    logic        hold;
    logic        pd;
    logic        wl;
    logic        bw;
    logic [8:0]  a;
    logic [63:0] d;
    hold = cache_ctrl_model_i.clock_hold;
    pd   = cache_ctrl_model_i.power_down;
    wl   = cache_ctrl_model_i.word_line;
    bw   = |cache_ctrl_model_i.bypass_write;
    a    = cache_ctrl_model_i.address;
    d    = cache_ctrl_model_i.write_data;
    if (!hold) data_reg = d;
    if (!pd && wl && bw) mem[a] = data_reg;
    if (!pd && bw) out_model = data_reg;
    else if (!pd && wl) out_model = mem[a];
    return out_model;
  endfunction

  task automatic check_out(input logic [63:0] e);
    compares++;
    if (data_out !== e || $isunknown(data_out))
    begin
      miscompares++;
      $display("Error at %0t: data out %h, expected %h", $time, data_out, e);
    end
  endtask

  // results lag their request by two calls
  task automatic step(input cache_sram_pkg::cycle_type k, input logic [8:0] a,
                      input logic [63:0] d, input logic [7:0] be, input logic h,
                      input logic p);
    cache_ctrl_model_i.issue(k, a, d, be, h, p);
    if (pend.size() == 2) check_out(pend.pop_front());
    pend.push_back(predict());
  endtask

  task automatic wrap_up();
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial
  begin
    seed = 9;
    miscompares = 0;
    compares = 0;
    cycles = 0;
    out_model = cache_sram_pkg::DOUT_RESET;
    reset_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    // output still shows its reset level before any access
    check_out(cache_sram_pkg::DOUT_RESET);
    // fill the pool, one enable bit at a time
    for (int i = 0; i < 8; i++)
      step(cache_sram_pkg::CYCLE_WRITE, 9'(i), {$random(seed), $random(seed)},
           8'h01 << i, 1'b0, 1'b0);
    step(cache_sram_pkg::CYCLE_WRITE, 9'h1FF, 64'hA5A5_0F0F_FFFF_0001, 8'h80, 1'b0, 1'b0);
    step(cache_sram_pkg::CYCLE_READ, 9'h1FF, 64'h0, 8'h00, 1'b0, 1'b0);
    step(cache_sram_pkg::CYCLE_BYPASS, 9'h003, 64'h1111_2222_3333_4444, 8'h10, 1'b0, 1'b0);
    step(cache_sram_pkg::CYCLE_BYPASS, 9'h003, 64'h5555_6666_7777_8888, 8'h04, 1'b1, 1'b0);
    step(cache_sram_pkg::CYCLE_READ, 9'h003, 64'h0, 8'h00, 1'b0, 1'b0);
    step(cache_sram_pkg::CYCLE_WRITE, 9'h005, 64'hDEAD_BEEF_0000_FFFF, 8'hFF, 1'b0, 1'b1);
    step(cache_sram_pkg::CYCLE_READ, 9'h005, 64'h0, 8'h00, 1'b0, 1'b0);
    step(cache_sram_pkg::CYCLE_IDLE, 9'h005, 64'h0, 8'h00, 1'b0, 1'b0);
    // random traffic over the pool and the top word
    repeat (400)
    begin
      r = $random(seed);
      step(cache_sram_pkg::cycle_type'(r[1:0]), r[5] ? 9'h1FF : {6'h00, r[4:2]},
           {$random(seed), $random(seed)}, r[13:6], r[16:14] == 3'h0, r[19:17] == 3'h0);
    end
    repeat (2) step(cache_sram_pkg::CYCLE_IDLE, 9'h000, 64'h0, 8'h00, 1'b0, 1'b0);
    wrap_up();
  end
endmodule
